// File: rtl/sts_pkg.sv
// Shared constants and types for the step test sequencer
package sts_pkg;

  localparam int unsigned STEP_COUNT_DEF = 8;
  localparam int unsigned DWELL_W_DEF = 16;
  localparam int unsigned STEP_ZERO = 0;

  typedef enum logic {
    STS_IDLE,
    STS_RUN
  } sts_run_e;

endpackage

// File: rtl/sts_done_select.sv
// Completion input selector and ring increment for the step counter
`timescale 1ns/1ps

module sts_done_select #(
  parameter int unsigned STEP_COUNT = sts_pkg::STEP_COUNT_DEF,
  parameter int unsigned STEP_W = $clog2(STEP_COUNT)
) (
  input wire logic [STEP_COUNT-1:0] step_done_inputs,
  input wire logic [STEP_W-1:0] step,
  output logic sel_done,
  output logic [STEP_W-1:0] step_inc,
  output logic step_last
);

  // Out-of-range step numbers read as not done, so a bad state cannot run away
  function automatic logic pick_done(input logic [STEP_COUNT-1:0] done,
                                     input logic [STEP_W-1:0] idx);
    logic hit;
    hit = 1'b0;
    for (int unsigned i = 0; i < STEP_COUNT; i++)
    begin
      if (idx == STEP_W'(i))
      begin
        hit = done[i];
      end
    end
    return hit;
  endfunction

  always_comb
  begin
    // [RQ3] Pick completion input
    sel_done = pick_done(step_done_inputs, step);
    step_last = (step == STEP_W'(STEP_COUNT - 1));
    // [RQ1] Wrap to zero
    if (step_last)
    begin
      step_inc = STEP_W'(sts_pkg::STEP_ZERO);
    end
    else
    begin
      step_inc = step + STEP_W'(1);
    end
  end

endmodule

// File: rtl/sts_sequencer.sv
// Step test sequencer: ring program counter, one-hot step selects, completion gating
`timescale 1ns/1ps

// What this block does
// [RQ1] The current step is held in a program counter that wraps from the last step to zero.
// [RQ2] The step number is decoded into one-hot step selects with only the current step's line high.
// [RQ3] The step number picks one completion input, held low by the test logic until its step ends.
// [RQ4] A low start pulse clears the counter to zero, raising the step-zero select.
// [RQ5] Outside async mode, a high selected completion input advances the counter on the next rising clock edge.
// [RQ6] With all completion inputs held high the counter advances on every clock outside async mode; in async mode it holds.
// [RQ7] A jump load enable loads the presented destination step instead of incrementing.
// [RQ8] An optional mode advances the counter on a falling edge of the selected completion input.
// [RQ9] The step count is a parameter that scales counter, decoder and selector together.
// [RQ10] A jump load in the same cycle as a count takes priority and loads the destination.
module sts_sequencer #(
  // [RQ9] Scaled step count
  parameter int unsigned STEP_COUNT = sts_pkg::STEP_COUNT_DEF,
  parameter int unsigned STEP_W = $clog2(STEP_COUNT),
  parameter int unsigned DWELL_W = sts_pkg::DWELL_W_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start_n,
  input wire logic [STEP_COUNT-1:0] step_done_inputs,
  input wire logic jump_load_enable,
  input wire logic [STEP_W-1:0] jump_target,
  input wire logic async_mode,
  output logic [STEP_COUNT-1:0] step_select_lines,
  output logic [STEP_W-1:0] step_number,
  output logic seq_running,
  output logic step_advance_pulse,
  output logic seq_wrap_pulse,
  output logic [DWELL_W-1:0] step_dwell_count
);

  sts_pkg::sts_run_e run_r;
  sts_pkg::sts_run_e run_nxt;
  logic [STEP_W-1:0] step_r;
  logic [STEP_W-1:0] step_nxt;
  logic done_prev_r;
  logic done_prev_nxt;
  logic [STEP_COUNT-1:0] select_r;
  logic [STEP_COUNT-1:0] select_nxt;
  logic adv_r;
  logic adv_nxt;
  logic wrap_r;
  logic wrap_nxt;
  logic [DWELL_W-1:0] dwell_r;
  logic [DWELL_W-1:0] dwell_nxt;

  logic sel_done;
  logic [STEP_W-1:0] step_inc;
  logic step_last;
  logic done_fall;
  logic count_en;
  logic target_ok;
  logic step_moved;

  // Decoder of the next step number into one select line per step
  function automatic logic [STEP_COUNT-1:0] step_onehot(input logic [STEP_W-1:0] idx);
    logic [STEP_COUNT-1:0] v;
    v = '0;
    for (int unsigned i = 0; i < STEP_COUNT; i++)
    begin
      v[i] = (idx == STEP_W'(i));
    end
    return v;
  endfunction

  sts_done_select #(
    .STEP_COUNT(STEP_COUNT),
    .STEP_W(STEP_W)
  ) u_done_select (
    .step_done_inputs(step_done_inputs),
    .step(step_r),
    .sel_done(sel_done),
    .step_inc(step_inc),
    .step_last(step_last)
  );

  always_comb
  begin
    // [RQ8] Falling edge of the selected input
    done_fall = done_prev_r & ~sel_done;
    // [RQ5] Count enable from completion level, or from its falling edge in async mode
    if (async_mode)
    begin
      count_en = done_fall;
    end
    else
    begin
      count_en = sel_done;
    end
    // Targets past the last step would leave every select low, so such loads are dropped
    target_ok = (jump_target <= STEP_W'(STEP_COUNT - 1));

    run_nxt = run_r;
    step_nxt = step_r;
    wrap_nxt = 1'b0;
    if (!start_n)
    begin
      // [RQ4] Start clears to step zero
      run_nxt = sts_pkg::STS_RUN;
      step_nxt = STEP_W'(sts_pkg::STEP_ZERO);
    end
    else if (run_r == sts_pkg::STS_RUN)
    begin
      if (jump_load_enable && target_ok)
      begin
        // [RQ7] [RQ10] Load wins over count
        step_nxt = jump_target;
      end
      else if (count_en)
      begin
        // [RQ5] [RQ6] Advance one step
        step_nxt = step_inc;
        wrap_nxt = step_last;
      end
    end

    step_moved = (step_nxt != step_r) || (count_en && (run_r == sts_pkg::STS_RUN) && start_n
                 && !(jump_load_enable && target_ok));
    adv_nxt = step_moved && start_n;

    // A fresh step must see its own input rise before a fall can count
    if (step_moved || !start_n)
    begin
      done_prev_nxt = 1'b0;
    end
    else
    begin
      done_prev_nxt = sel_done;
    end
  end

  // Sequence state and pulses register together
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      run_r <= sts_pkg::STS_IDLE;
      step_r <= '0;
      done_prev_r <= 1'b0;
      adv_r <= 1'b0;
      wrap_r <= 1'b0;
    end
    else
    begin
      run_r <= run_nxt;
      step_r <= step_nxt;
      done_prev_r <= done_prev_nxt;
      adv_r <= adv_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  // Selects follow the next step so they line up with the step number
  always_comb
  begin
    // [RQ2] One-hot step select
    if (run_nxt == sts_pkg::STS_RUN)
    begin
      select_nxt = step_onehot(step_nxt);
    end
    else
    begin
      select_nxt = '0;
    end
  end

  // Selects come from flip-flops so the step lines never glitch
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      select_r <= '0;
    end
    else
    begin
      select_r <= select_nxt;
    end
  end

  always_comb
  begin
    // Dwell counter saturates rather than wrapping, so long stalls stay visible
    if (step_moved || !start_n || (run_nxt != sts_pkg::STS_RUN))
    begin
      dwell_nxt = '0;
    end
    else if (dwell_r != {DWELL_W{1'b1}})
    begin
      dwell_nxt = dwell_r + DWELL_W'(1);
    end
    else
    begin
      dwell_nxt = dwell_r;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dwell_r <= '0;
    end
    else
    begin
      dwell_r <= dwell_nxt;
    end
  end

  assign step_select_lines = select_r;
  assign step_number = step_r;
  assign seq_running = (run_r == sts_pkg::STS_RUN);
  assign step_advance_pulse = adv_r;
  assign seq_wrap_pulse = wrap_r;
  assign step_dwell_count = dwell_r;

endmodule

// File: dv/sts_unit_model.sv
// Behavioural per-step test units reporting completion
`timescale 1ns/1ps
module sts_unit_model (
  input wire logic ref_clk,
  input wire logic [7:0] step_select_lines,
  input wire logic [3:0] lat,
  output logic [7:0] step_done_inputs
);
  logic [3:0] cnt;
  logic [7:0] prev;
  initial
  begin
    cnt = 4'h0;
    prev = 8'h00;
    step_done_inputs = 8'h00;
  end
  // Low until done
  // Latency f ties every input high; otherwise a one-cycle done pulse
  // Case compare keeps unknown selects before reset from poisoning the counter
  always @(posedge ref_clk)
  begin
    cnt <= (step_done_inputs !== 8'h00 || step_select_lines !== prev) ? 4'h0 : cnt + 4'h1;
    prev <= step_select_lines;
    step_done_inputs <= (lat == 4'hf) ? 8'hff : (cnt == lat ? step_select_lines : 8'h00);
  end
endmodule

// File: dv/sts_properties.sv
// Port checker for the step sequencer
`timescale 1ns/1ps
module sts_chk #(
  parameter int unsigned STEP_COUNT = 8,
  parameter int unsigned STEP_W = 3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start_n,
  input wire logic [STEP_COUNT-1:0] step_done_inputs,
  input wire logic jump_load_enable,
  input wire logic [STEP_W-1:0] jump_target,
  input wire logic async_mode,
  input wire logic [STEP_COUNT-1:0] step_select_lines,
  input wire logic [STEP_W-1:0] step_number,
  input wire logic seq_running,
  input wire logic step_advance_pulse,
  input wire logic seq_wrap_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic go;
  assign go = start_n && seq_running && !jump_load_enable;
  property p_sel; seq_running |-> step_select_lines == (STEP_COUNT'(1) << step_number); endproperty
  property p_idl; !seq_running |-> step_select_lines == '0; endproperty
  property p_sta; !start_n |=> seq_running && step_number == '0; endproperty
  property p_cnt; go && !async_mode && step_done_inputs[step_number]
    |=> step_number == STEP_W'($past(step_number) + 1'b1); endproperty
  property p_hld; go && !async_mode && !step_done_inputs[step_number] |=> $stable(step_number);
  endproperty
  property p_jmp; start_n && seq_running && jump_load_enable && jump_target < STEP_COUNT
    |=> step_number == $past(jump_target); endproperty
  property p_adv; !$past(rst) && $past(start_n) && $changed(step_number)
    |-> step_advance_pulse; endproperty
  property p_wrp; seq_wrap_pulse |-> step_number == '0 && step_advance_pulse; endproperty
  a_sel: assert property (p_sel) else $error("select");
  a_idl: assert property (p_idl) else $error("idle");
  a_sta: assert property (p_sta) else $error("start");
  a_cnt: assert property (p_cnt) else $error("count");
  a_hld: assert property (p_hld) else $error("hold");
  a_jmp: assert property (p_jmp) else $error("jump");
  a_adv: assert property (p_adv) else $error("pulse");
  a_wrp: assert property (p_wrp) else $error("wrap");
  c_wrp: cover property (seq_wrap_pulse);
  c_jmp: cover property (jump_load_enable && seq_running);
  c_asy: cover property (async_mode && step_advance_pulse);
endmodule
bind sts_sequencer sts_chk #(.STEP_COUNT(STEP_COUNT), .STEP_W(STEP_W)) sts_chk_i (
  .ref_clk(ref_clk),
  .rst(rst),
  .start_n(start_n),
  .step_done_inputs(step_done_inputs),
  .jump_load_enable(jump_load_enable),
  .jump_target(jump_target),
  .async_mode(async_mode),
  .step_select_lines(step_select_lines),
  .step_number(step_number),
  .seq_running(seq_running),
  .step_advance_pulse(step_advance_pulse),
  .seq_wrap_pulse(seq_wrap_pulse)
);

// File: dv/test_step_test_sequencer.sv
// Self-checking bench for the step sequencer
`timescale 1ns/1ps
module test_step_test_sequencer;
  logic ref_clk, rst, start_n, jump_load_enable, async_mode;
  logic [2:0] jump_target, step_number, s;
  logic [7:0] step_done_inputs, step_select_lines;
  logic [3:0] lat;
  logic [15:0] step_dwell_count;
  int errors = 0, checks_done = 0, cyc = 0;
  sts_sequencer sts_sequencer_i (.ref_clk, .rst, .start_n, .step_done_inputs,
    .jump_load_enable, .jump_target, .async_mode, .step_select_lines, .step_number,
    .seq_running(), .step_advance_pulse(), .seq_wrap_pulse(), .step_dwell_count);
  sts_unit_model sts_unit_model_i (.ref_clk, .step_select_lines, .lat, .step_done_inputs);
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      give_verdict();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task give_verdict();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task wait_step(input logic [2:0] w);
    for (int n = 0; n < 40 && step_number !== w; n++)
      tick(1);
    chk(step_number, w);
  endtask
  task t_start();
    chk(step_select_lines, 8'h00);
    start_n = 1'b0;
    tick(1);
    start_n = 1'b1;
    chk(step_select_lines, 8'h01);
    tick(3);
    chk(step_number, 8'h00);
    chk(step_dwell_count, 16'h0003);
  endtask
  task t_ring();
    lat = 4'h0;
    for (int k = 1; k < 10; k++)
    begin
      wait_step(3'(k));
      chk(step_select_lines, 8'h01 << (k % 8));
    end
  endtask
  task t_all();
    lat = 4'hf;
    tick(2);
    s = step_number;
    repeat (8)
    begin
      tick(1);
      s++;
      chk(step_number, s);
    end
  endtask
  task t_jump();
    jump_load_enable = 1'b1;
    jump_target = 3'h5;
    tick(1);
    jump_load_enable = 1'b0;
    chk(step_number, 8'h05);
  endtask
  task t_async();
    async_mode = 1'b1;
    s = step_number;
    tick(3);
    chk(step_number, s);
    lat = 4'h2;
    wait_step(s + 3'h2);
  endtask
  initial
  begin
    rst = 1'b1;
    start_n = 1'b1;
    jump_load_enable = 1'b0;
    jump_target = 3'h0;
    async_mode = 1'b0;
    lat = 4'h5;
    tick(2);
    rst = 1'b0;
    tick(1);
    t_start();
    t_ring();
    t_all();
    t_jump();
    t_async();
    give_verdict();
  end
endmodule
